// ===== core/rdr_top.sv
`timescale 1ns/1ps
module rdr_top
#(
	parameter int BASE_DIV = rdr_pkg::BASE_DIV,
	parameter int HUND_DIV = rdr_pkg::HUND_DIV
)
(
	input wire logic i_mclk,
	input wire logic i_sys_rst,
	input wire rdr_pkg::rdr_ctrl_wr_type i_ctrl_wr_lo,
	input wire rdr_pkg::rdr_ctrl_wr_type i_ctrl_wr_hi,
	input wire rdr_pkg::rdr_evt_type i_evt_req,
	input wire logic i_event_input_pin,
	input wire logic i_event_flag_clr,
	output rdr_pkg::rdr_ctrl_type o_ctrl_lo,
	output rdr_pkg::rdr_ctrl_type o_ctrl_hi,
	output logic [rdr_pkg::TAP_W-1:0] o_taps,
	output logic o_sec_tick,
	output logic [7:0] o_hundredths,
	output rdr_pkg::rdr_evt_type o_evt,
	output logic o_event_flag,
	output logic o_event_stamp_bad,
	output logic o_int_pin_out,
	output logic o_int_pin_oe_n
);

	localparam int BASE_W = $clog2(BASE_DIV);
	localparam int HUND_W = $clog2(HUND_DIV);

	// ****************************************************************
	// elaboration checks
	// ****************************************************************
	generate
		if (BASE_DIV < 2 || HUND_DIV < 2)
		begin : g_bad_div
			$error("rdr_top: dividers must be at least 2");
		end
	endgenerate

	// ****************************************************************
	// control bits
	// ****************************************************************
	rdr_pkg::rdr_ctrl_type ctrl;
	rdr_pkg::rdr_ctrl_type next_ctrl;

	// one store behind both windows; upper copy wins a same-cycle clash
	always_comb
	begin
		next_ctrl = ctrl;
		if (i_ctrl_wr_lo.stb)
			next_ctrl = i_ctrl_wr_lo.data;
		if (i_ctrl_wr_hi.stb)
			next_ctrl = i_ctrl_wr_hi.data;
	end

	always_ff @(posedge i_mclk)
	begin
		if (i_sys_rst)
		begin
			ctrl.reset_stop <= rdr_pkg::RESET_STOP_RESET;
			ctrl.ext_event_irq_enable <= rdr_pkg::EVENT_ENABLE_RESET;
		end
		else
			ctrl <= next_ctrl;
	end

	// ****************************************************************
	// prescaler chain
	// ****************************************************************
	logic [BASE_W-1:0] base_cnt;
	logic [BASE_W-1:0] next_base_cnt;
	logic [rdr_pkg::CHAIN_W-1:0] chain;
	logic [rdr_pkg::CHAIN_W-1:0] next_chain;
	logic sec_tick;
	logic next_sec_tick;
	logic base_tick;

	assign base_tick = (base_cnt == BASE_W'(BASE_DIV - 1));

	// chain wraps once per second; taps are its low bits
	always_comb
	begin
		next_base_cnt = base_cnt;
		next_chain = chain;
		next_sec_tick = 1'b0;
		if (ctrl.reset_stop)
		begin
			next_base_cnt = '0;
			next_chain = '0;
		end
		else if (base_tick)
		begin
			next_base_cnt = '0;
			next_chain = chain + 1'b1;
			next_sec_tick = (chain == '1);
		end
		else
			next_base_cnt = base_cnt + 1'b1;
	end

	always_ff @(posedge i_mclk)
	begin
		if (i_sys_rst)
		begin
			base_cnt <= '0;
			chain <= '0;
			sec_tick <= 1'b0;
		end
		else
		begin
			base_cnt <= next_base_cnt;
			chain <= next_chain;
			sec_tick <= next_sec_tick;
		end
	end

	// ****************************************************************
	// hundredths counter
	// ****************************************************************
	logic [HUND_W-1:0] hund_cnt;
	logic [HUND_W-1:0] next_hund_cnt;
	logic [7:0] hund;
	logic [7:0] next_hund;

	// separate divider, since 100 Hz is not a binary tap of the chain
	always_comb
	begin
		next_hund_cnt = hund_cnt;
		next_hund = hund;
		if (ctrl.reset_stop)
		begin
			next_hund_cnt = '0;
			next_hund = rdr_pkg::HUND_RESET;
		end
		else if (hund_cnt == HUND_W'(HUND_DIV - 1))
		begin
			next_hund_cnt = '0;
			if (hund[3:0] != rdr_pkg::BCD_MAX)
				next_hund[3:0] = hund[3:0] + 4'h1;
			else
			begin
				next_hund[3:0] = rdr_pkg::BCD_ZERO;
				if (hund[7:4] != rdr_pkg::BCD_MAX)
					next_hund[7:4] = hund[7:4] + 4'h1;
				else
					next_hund[7:4] = rdr_pkg::BCD_ZERO;
			end
		end
		else
			next_hund_cnt = hund_cnt + 1'b1;
	end

	always_ff @(posedge i_mclk)
	begin
		if (i_sys_rst)
		begin
			hund_cnt <= '0;
			hund <= rdr_pkg::HUND_RESET;
		end
		else
		begin
			hund_cnt <= next_hund_cnt;
			hund <= next_hund;
		end
	end

	// ****************************************************************
	// time-based interrupt gating
	// ****************************************************************
	rdr_pkg::rdr_evt_type evt;
	rdr_pkg::rdr_evt_type next_evt;

	// requests arriving under reset/stop are dropped, not deferred
	always_comb
	begin
		next_evt = i_evt_req;
		if (ctrl.reset_stop)
			next_evt = '0;
	end

	always_ff @(posedge i_mclk)
	begin
		if (i_sys_rst)
			evt <= '0;
		else
			evt <= next_evt;
	end

	// ****************************************************************
	// external event path
	// ****************************************************************
	logic pin_level;
	logic pin_prev;
	logic flag;
	logic next_flag;
	logic stamp_bad;
	logic next_stamp_bad;
	logic int_oe_n;
	logic next_int_oe_n;
	logic event_hit;

	rdr_sync u_sync
	(
		.i_mclk(i_mclk),
		.i_sys_rst(i_sys_rst),
		.i_async(i_event_input_pin),
		.o_level(pin_level)
	);

	assign event_hit = pin_level & ~pin_prev;

	// not gated by reset/stop; set wins over a same-cycle clear
	always_comb
	begin
		next_flag = (flag & ~i_event_flag_clr) | event_hit;
		next_stamp_bad = stamp_bad;
		if (event_hit)
			next_stamp_bad = ctrl.reset_stop;
		next_int_oe_n = ~(next_flag & ctrl.ext_event_irq_enable);
	end

	always_ff @(posedge i_mclk)
	begin
		if (i_sys_rst)
		begin
			pin_prev <= 1'b0;
			flag <= 1'b0;
			stamp_bad <= 1'b0;
			int_oe_n <= 1'b1;
		end
		else
		begin
			pin_prev <= pin_level;
			flag <= next_flag;
			stamp_bad <= next_stamp_bad;
			int_oe_n <= next_int_oe_n;
		end
	end

	// ****************************************************************
	// outputs
	// ****************************************************************
	assign o_ctrl_lo = ctrl;
	assign o_ctrl_hi = ctrl;
	assign o_taps = chain[rdr_pkg::TAP_W-1:0];
	assign o_sec_tick = sec_tick;
	assign o_hundredths = hund;
	assign o_evt = evt;
	assign o_event_flag = flag;
	assign o_event_stamp_bad = stamp_bad;
	assign o_int_pin_out = 1'b0; // open drain: only ever pulls low
	assign o_int_pin_oe_n = int_oe_n;

endmodule

// ===== include/rdr_pkg.sv
package rdr_pkg;

	// ****************************************************************
	// timing
	// ****************************************************************
	localparam int CLK_HZ = 50_000_000;
	localparam int TOP_TAP_HZ = 4096;
	localparam int CHAIN_TICK_HZ = 2 * TOP_TAP_HZ;
	localparam int BASE_DIV = CLK_HZ / CHAIN_TICK_HZ;
	localparam int HUND_HZ = 100;
	localparam int HUND_DIV = CLK_HZ / HUND_HZ;
	localparam int CHAIN_W = 13;
	localparam int TAP_W = 12;

	// ****************************************************************
	// reset values and digits
	// ****************************************************************
	localparam logic [7:0] HUND_RESET = 8'h00;
	localparam logic [3:0] BCD_MAX = 4'h9;
	localparam logic [3:0] BCD_ZERO = 4'h0;
	localparam logic RESET_STOP_RESET = 1'h0;
	localparam logic EVENT_ENABLE_RESET = 1'h0;

	// ****************************************************************
	// carriers
	// ****************************************************************
	typedef struct packed {
		logic reset_stop;
		logic ext_event_irq_enable;
	} rdr_ctrl_type;

	typedef struct packed {
		logic stb;
		rdr_ctrl_type data;
	} rdr_ctrl_wr_type;

	typedef struct packed {
		logic timer;
		logic update;
		logic alarm;
	} rdr_evt_type;

endpackage

// ===== core/rdr_sync.sv
`timescale 1ns/1ps
module rdr_sync
(
	input wire logic i_mclk,
	input wire logic i_sys_rst,
	input wire logic i_async,
	output logic o_level
);

	logic s1;
	logic s2;
	logic s3;
	logic level;
	logic next_level;

	// level moves only once the second and third stages agree
	always_comb
	begin
		next_level = level;
		if (s2 == s3)
			next_level = s3;
	end

	// s1 feeds s2 only, to keep metastability out of the compare
	always_ff @(posedge i_mclk)
	begin
		if (i_sys_rst)
		begin
			s1 <= 1'b0;
			s2 <= 1'b0;
			s3 <= 1'b0;
			level <= 1'b0;
		end
		else
		begin
			s1 <= i_async;
			s2 <= s1;
			s3 <= s2;
			level <= next_level;
		end
	end

	assign o_level = level;

endmodule

// ===== bench/rdr_evt_src.sv
`timescale 1ns/1ps
module rdr_evt_src
(
	input wire logic i_mclk,
	input wire logic i_fire,
	output logic o_pin
);
	logic [2:0] cnt = 3'h0;
	// pulse held four cycles so the three-stage sync always sees it
	always_ff @(posedge i_mclk)
	begin
		cnt <= i_fire ? 3'h4 : (cnt != 3'h0 ? cnt - 3'h1 : 3'h0);
		o_pin <= i_fire || cnt > 3'h1;
	end
endmodule

// ===== bench/rdr_props.sv
`timescale 1ns/1ps
module rdr_props
(
	input wire logic i_mclk,
	input wire logic i_sys_rst,
	input wire rdr_pkg::rdr_ctrl_wr_type i_ctrl_wr_lo,
	input wire rdr_pkg::rdr_ctrl_wr_type i_ctrl_wr_hi,
	input wire rdr_pkg::rdr_evt_type i_evt_req,
	input wire rdr_pkg::rdr_ctrl_type o_ctrl_lo,
	input wire rdr_pkg::rdr_ctrl_type o_ctrl_hi,
	input wire logic [11:0] o_taps,
	input wire logic o_sec_tick,
	input wire logic [7:0] o_hundredths,
	input wire rdr_pkg::rdr_evt_type o_evt,
	input wire logic o_event_flag,
	input wire logic o_event_stamp_bad,
	input wire logic o_int_pin_oe_n
);
	// **********
	// one clock domain, so one default clocking
	// **********
	default clocking cb @(posedge i_mclk); endclocking
	default disable iff (i_sys_rst);
	chk_mirror_same: assert property (o_ctrl_lo == o_ctrl_hi)
		else $error("mirror copies differ");
	chk_write_lands: assert property ((i_ctrl_wr_lo.stb || i_ctrl_wr_hi.stb) |=>
		o_ctrl_lo == ($past(i_ctrl_wr_hi.stb) ? $past(i_ctrl_wr_hi.data)
		: $past(i_ctrl_wr_lo.data)))
		else $error("write not taken");
	chk_taps_clear: assert property (o_ctrl_lo.reset_stop |=> o_taps == 12'h000)
		else $error("taps run while stopped");
	chk_tick_halt: assert property (o_ctrl_lo.reset_stop [*2] |=> !o_sec_tick)
		else $error("tick while stopped");
	chk_hund_zero: assert property (o_ctrl_lo.reset_stop |=> o_hundredths == 8'h00)
		else $error("hundredths not cleared");
	chk_evt_gate: assert property (1'b1 |=>
		o_evt == ($past(i_evt_req) & {3{!$past(o_ctrl_lo.reset_stop)}}))
		else $error("time event gating wrong");
	chk_stamp_flag: assert property ($rose(o_event_flag) && o_ctrl_lo.reset_stop
		&& $past(o_ctrl_lo.reset_stop) |-> o_event_stamp_bad)
		else $error("stamp not marked");
	chk_stamp_good: assert property ($rose(o_event_flag) &&
		!$past(o_ctrl_lo.reset_stop) |-> !o_event_stamp_bad)
		else $error("stamp marked while running");
	chk_irq_off: assert property (!o_ctrl_lo.ext_event_irq_enable |=> o_int_pin_oe_n)
		else $error("irq without enable");
	chk_irq_cause: assert property (!o_int_pin_oe_n |-> o_event_flag)
		else $error("irq without flag");
	chk_reset_vals: assert property ($past(i_sys_rst) |-> o_ctrl_lo == 2'h0
		&& o_int_pin_oe_n && !o_event_flag)
		else $error("bad reset values");
endmodule
bind rdr_top rdr_props u_props (.*);

// ===== bench/test_rdr_top.sv
`timescale 1ns/1ps
module test_rdr_top;
	logic i_mclk = 1'b0, rst = 1'b1, fire = 1'b0, clr = 1'b0, pin;
	rdr_pkg::rdr_ctrl_wr_type wr_lo = '0, wr_hi = '0;
	rdr_pkg::rdr_evt_type req = '0;
	rdr_pkg::rdr_ctrl_type c_lo, c_hi;
	rdr_pkg::rdr_evt_type ev;
	logic [11:0] taps;
	logic [7:0] hund;
	logic tick, flag, bad, pout, oe_n;
	int num_errors = 0, checks = 0, cyc = 0, n;
	rdr_top #(.BASE_DIV(4), .HUND_DIV(10)) dut (.i_mclk(i_mclk), .i_sys_rst(rst),
		.i_ctrl_wr_lo(wr_lo), .i_ctrl_wr_hi(wr_hi), .i_evt_req(req),
		.i_event_input_pin(pin), .i_event_flag_clr(clr), .o_ctrl_lo(c_lo),
		.o_ctrl_hi(c_hi), .o_taps(taps), .o_sec_tick(tick), .o_hundredths(hund),
		.o_evt(ev), .o_event_flag(flag), .o_event_stamp_bad(bad),
		.o_int_pin_out(pout), .o_int_pin_oe_n(oe_n));
	rdr_evt_src src (.i_mclk(i_mclk), .i_fire(fire), .o_pin(pin));
	// clock and hang guard; the 1 Hz wait dominates the run
	initial forever #10 i_mclk = ~i_mclk;
	always @(posedge i_mclk)
	begin
		cyc++;
		if (cyc == 50000)
		begin
			num_errors++;
			finish_test();
		end
	end
	// wide enough for the taps and hundredths together
	task automatic chk(input logic [19:0] got, input logic [19:0] exp);
		checks++;
		if (got !== exp)
		begin
			num_errors++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic hi, input logic rs, input logic en);
		@(posedge i_mclk);
		if (hi) wr_hi <= {1'b1, rs, en};
		else wr_lo <= {1'b1, rs, en};
		@(posedge i_mclk);
		wr_hi.stb <= 1'b0;
		wr_lo.stb <= 1'b0;
		#1;
	endtask
	task automatic pulse_evt(input logic [2:0] exp);
		@(posedge i_mclk) req <= 3'h7;
		@(posedge i_mclk) req <= 3'h0;
		#1 chk(ev, exp);
	endtask
	// fire the pin, then give the sync chain a bounded wait
	task automatic shoot();
		@(posedge i_mclk) fire <= 1'b1;
		@(posedge i_mclk) fire <= 1'b0;
		// look after the edge has settled, not in its own time step
		for (n = 0; n < 20 && flag !== 1'b1; n++) @(posedge i_mclk) #1;
		#1 chk(flag, 1);
	endtask
	task automatic clear_flag();
		@(posedge i_mclk) clr <= 1'b1;
		@(posedge i_mclk) clr <= 1'b0;
		#1 chk({flag, oe_n}, 12'h1);
	endtask
	task automatic t_mirror();
		wr(0, 0, 1);
		chk(c_hi, 2'h1);
		wr(1, 1, 0);
		chk(c_lo, 2'h2);
		@(posedge i_mclk);
		wr_lo <= 3'h7;
		wr_hi <= 3'h4;
		wr(1, 0, 0);
		chk({c_lo, c_hi}, 12'h0);
	endtask
	task automatic t_run();
		repeat (35) @(posedge i_mclk);
		#1 chk(hund inside {8'h02, 8'h03, 8'h04}, 1);
		pulse_evt(3'h7);
		for (n = 40; n < 33000 && tick !== 1'b1; n++) @(posedge i_mclk) #1;
		chk(n >= 32760 && n <= 32780, 1);
	endtask
	task automatic t_stop();
		wr(0, 1, 1);
		@(posedge i_mclk) #1;
		chk({taps, hund}, 12'h0);
		repeat (60) @(posedge i_mclk);
		#1 chk({taps, hund}, 12'h0);
		pulse_evt(3'h0);
		shoot();
		chk({bad, oe_n}, 12'h2);
		clear_flag();
	endtask
	task automatic t_enable();
		wr(1, 0, 0);
		shoot();
		chk(oe_n, 1);
		chk(bad, 0);
		wr(0, 0, 1);
		@(posedge i_mclk) #1 chk(oe_n, 0);
		chk(pout, 0);
		clear_flag();
	endtask
	task automatic finish_test();
		$display("errors %0d checks %0d", num_errors, checks);
		if (num_errors == 0 && checks > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask
	// **********
	// main sequence
	// **********
	initial
	begin
		repeat (8) @(posedge i_mclk);
		rst <= 1'b0;
		@(posedge i_mclk) #1;
		chk({c_lo, c_hi, taps[0], hund[0], oe_n, flag}, 12'h2);
		t_mirror();
		t_run();
		t_stop();
		t_enable();
		finish_test();
	end
endmodule
